// ### rtl/i2cr_buf2.v
// small first-in first-out buffer between register source and byte shifter
// assumes one clock, synchronous active-high reset, flush from the same clock
`timescale 1ns/10ps
module i2cr_buf2 #(
  parameter WIDTH = 8,
  parameter DEPTH = 2,
  parameter AW    = 1
) (
  sys_clk,
  reset,
  flush,
  in_valid,
  in_ready,
  in_data,
  out_valid,
  out_ready,
  out_data
);
  input  wire             sys_clk;
  input  wire             reset;
  input  wire             flush;
  input  wire             in_valid;
  output wire             in_ready;
  input  wire [WIDTH-1:0] in_data;
  output wire             out_valid;
  input  wire             out_ready;
  output wire [WIDTH-1:0] out_data;

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  reg [AW:0]      count_d;
  reg             ready_q;
  reg             valid_q;
  wire            push;
  wire            pop;

  assign push      = in_valid & ready_q;
  assign pop       = out_ready & valid_q;
  assign in_ready  = ready_q;
  assign out_valid = valid_q;
  assign out_data  = mem_q[rd_ptr_q];

  function [AW-1:0] next_ptr;
    input [AW-1:0] p;
    begin
      if (p == DEPTH - 1)
        next_ptr = {AW{1'b0}};
      else
        next_ptr = p + 1'b1;
    end
  endfunction

  always @* begin
    count_d = count_q;
    if (flush)
      count_d = {(AW+1){1'b0}};
    else if (push & ~pop)
      count_d = count_q + 1'b1;
    else if (pop & ~push)
      count_d = count_q - 1'b1;
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
      ready_q  <= 1'b0;
      valid_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      // ready and valid registered so the ports come straight from flops
      ready_q <= (count_d < DEPTH);
      valid_q <= (count_d != 0);
      if (flush) begin
        wr_ptr_q <= {AW{1'b0}};
        rd_ptr_q <= {AW{1'b0}};
      end else begin
        if (push)
          wr_ptr_q <= next_ptr(wr_ptr_q);
        if (pop)
          rd_ptr_q <= next_ptr(rd_ptr_q);
      end
    end
  end

  always @(posedge sys_clk) begin
    if (push & ~flush)
      mem_q[wr_ptr_q] <= in_data;
  end
endmodule

// ### rtl/i2cr_defines.vh
// constants for the serial-bus register read slave
// assumes inclusion by bare name from the design files
`ifndef I2CR_DEFINES_VH
`define I2CR_DEFINES_VH
`define I2CR_SLAVE_ADDR      7'h31
`define I2CR_READ_ADDR_BYTE  8'h63
`define I2CR_BITS_PER_BYTE   4'h8
`define I2CR_IDLE_BYTE       8'hFF
`define I2CR_STRAP_SETTLE    2'h3
`define I2CR_ADDR_W          16
`define I2CR_DATA_W          8
`define I2CR_BUF_DEPTH       2
`endif

// ### rtl/i2cr_slave_read.v
// serial-bus slave: read command path, mode strap capture and alarm pin
// assumes scl/sda/strap arrive asynchronously; register source and
// power-up sequencer run on sys_clk; write path owns target_addr
// Operation
// - acknowledge a read address byte whose seven address bits are 0110001b, else nack.
// - first byte from the target address, each further byte from the next address.
// - after a master nack, ignore the bus until the next start condition.
// - strap high selects master-mode power-up load, low leaves load to master.
// - alarm is shown by pulling the open-drain active-low pin low only.
// - while power-up holds the alarm low, every bus access is ignored; the code tests powerup_busy only at a start condition.
// - bytes go most significant bit first, followed by a ninth acknowledge clock.
`timescale 1ns/10ps
`include "i2cr_defines.vh"
module i2cr_slave_read #(
  parameter ADDR_W = `I2CR_ADDR_W,
  parameter DATA_W = `I2CR_DATA_W
) (
  sys_clk,
  reset,
  scl_in,
  sda_in,
  sda_out,
  sda_oe,
  mode_strap_in,
  master_boot,
  strap_valid,
  powerup_busy,
  alarm_req,
  alarm_out_n,
  alarm_oe,
  target_addr,
  rd_req,
  rd_addr,
  rd_data,
  rd_valid,
  rd_ready,
  read_active
);
  input  wire              sys_clk;
  input  wire              reset;
  input  wire              scl_in;
  input  wire              sda_in;
  output wire              sda_out;
  output wire              sda_oe;
  input  wire              mode_strap_in;
  output wire              master_boot;
  output wire              strap_valid;
  input  wire              powerup_busy;
  input  wire              alarm_req;
  output wire              alarm_out_n;
  output wire              alarm_oe;
  input  wire [ADDR_W-1:0] target_addr;
  output wire              rd_req;
  output wire [ADDR_W-1:0] rd_addr;
  input  wire [DATA_W-1:0] rd_data;
  input  wire              rd_valid;
  output wire              rd_ready;
  output wire              read_active;

  localparam [5:0] ST_IDLE   = 6'h01;
  localparam [5:0] ST_ADDR   = 6'h02;
  localparam [5:0] ST_AACK   = 6'h04;
  localparam [5:0] ST_TX     = 6'h08;
  localparam [5:0] ST_TXACK  = 6'h10;
  localparam [5:0] ST_IGNORE = 6'h20;

  reg              scl_s1_q, scl_s2_q, scl_s3_q;
  reg              sda_s1_q, sda_s2_q, sda_s3_q;
  reg              strap_s1_q, strap_s2_q;
  reg  [1:0]       settle_q;
  reg              strap_valid_q;
  reg              master_boot_q;
  reg  [5:0]       st_q;
  reg  [3:0]       bit_cnt_q;
  reg  [7:0]       shift_q;
  reg  [DATA_W-1:0] tx_q;
  reg              acked_q;
  reg              sda_oe_q;
  reg              alarm_oe_q;
  reg              active_q;
  reg              pend_q;
  reg              rd_req_q;
  reg  [ADDR_W-1:0] rd_addr_q;
  reg  [ADDR_W-1:0] fetch_addr_q;
  wire             scl_rise, scl_fall, bus_start, bus_stop;
  wire             load_now, addr_hit, flush, buf_push, buf_pop;
  wire             buf_in_ready, buf_valid;
  wire [DATA_W-1:0] buf_data;
  wire [DATA_W-1:0] next_byte;

  // edge detectors look only at second and third stages
  assign scl_rise  = scl_s2_q & ~scl_s3_q;
  assign scl_fall  = ~scl_s2_q & scl_s3_q;
  assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign bus_stop  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

  assign addr_hit  = (st_q == ST_ADDR) & scl_fall & (bit_cnt_q == `I2CR_BITS_PER_BYTE) &
                     (shift_q == `I2CR_READ_ADDR_BYTE) & (shift_q[7:1] == `I2CR_SLAVE_ADDR);
  assign load_now  = scl_fall & ((st_q == ST_AACK) | ((st_q == ST_TXACK) & acked_q));
  // an empty buffer at byte start sends all ones: no clock stretching here
  assign next_byte = buf_valid ? buf_data : `I2CR_IDLE_BYTE;
  assign buf_pop   = load_now & buf_valid;
  assign flush     = bus_start | bus_stop |
                     ((st_q == ST_TXACK) & scl_rise & sda_s2_q);
  // words answered after a flush are accepted and dropped
  assign buf_push  = rd_valid & active_q;

  assign sda_out     = 1'b0;
  assign sda_oe      = sda_oe_q;
  assign alarm_out_n = 1'b0;
  assign alarm_oe    = alarm_oe_q;
  assign master_boot = master_boot_q;
  assign strap_valid = strap_valid_q;
  assign rd_req      = rd_req_q;
  assign rd_addr     = rd_addr_q;
  assign read_active = active_q;

  i2cr_buf2 #(
    .WIDTH (DATA_W),
    .DEPTH (`I2CR_BUF_DEPTH),
    .AW    (1)
  ) u_buf (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .flush     (flush),
    .in_valid  (buf_push),
    .in_ready  (buf_in_ready),
    .in_data   (rd_data),
    .out_valid (buf_valid),
    .out_ready (load_now),
    .out_data  (buf_data)
  );
  assign rd_ready = buf_in_ready;

  always @(posedge sys_clk) begin
    if (reset) begin
      scl_s1_q   <= 1'b1;
      scl_s2_q   <= 1'b1;
      scl_s3_q   <= 1'b1;
      sda_s1_q   <= 1'b1;
      sda_s2_q   <= 1'b1;
      sda_s3_q   <= 1'b1;
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end else begin
      scl_s1_q   <= scl_in;
      scl_s2_q   <= scl_s1_q;
      scl_s3_q   <= scl_s2_q;
      sda_s1_q   <= sda_in;
      sda_s2_q   <= sda_s1_q;
      sda_s3_q   <= sda_s2_q;
      strap_s1_q <= mode_strap_in;
      strap_s2_q <= strap_s1_q;
    end
  end

  // strap caught once, after the synchroniser has filled since release
  always @(posedge sys_clk) begin
    if (reset) begin
      settle_q      <= 2'h0;
      strap_valid_q <= 1'b0;
      master_boot_q <= 1'b0;
    end else if (!strap_valid_q) begin
      if (settle_q == `I2CR_STRAP_SETTLE) begin
        strap_valid_q <= 1'b1;
        master_boot_q <= strap_s2_q;
      end else begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (reset)
      alarm_oe_q <= 1'b0;
    else
      alarm_oe_q <= powerup_busy | alarm_req;
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      st_q      <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= {DATA_W{1'b1}};
      acked_q   <= 1'b0;
      sda_oe_q  <= 1'b0;
    end else if (bus_start) begin
      sda_oe_q  <= 1'b0;
      bit_cnt_q <= 4'h0;
      acked_q   <= 1'b0;
      st_q      <= powerup_busy ? ST_IGNORE : ST_ADDR;
    end else if (bus_stop) begin
      sda_oe_q <= 1'b0;
      st_q     <= ST_IDLE;
    end else if (load_now) begin
      tx_q      <= next_byte;
      sda_oe_q  <= ~next_byte[DATA_W-1];
      bit_cnt_q <= 4'h1;
      acked_q   <= 1'b0;
      st_q      <= ST_TX;
    end else begin
      case (st_q)
        ST_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise && bit_cnt_q != `I2CR_BITS_PER_BYTE) begin
            shift_q   <= {shift_q[6:0], sda_s2_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == `I2CR_BITS_PER_BYTE) begin
            // write direction belongs to the write path; released line is a nack
            if (addr_hit) begin
              sda_oe_q <= 1'b1;
              st_q     <= ST_AACK;
            end else begin
              st_q <= ST_IGNORE;
            end
          end
        end
        ST_AACK: begin
          sda_oe_q <= 1'b1;
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_q == `I2CR_BITS_PER_BYTE) begin
              sda_oe_q <= 1'b0;
              st_q     <= ST_TXACK;
            end else begin
              tx_q      <= {tx_q[DATA_W-2:0], 1'b1};
              sda_oe_q  <= ~tx_q[DATA_W-2];
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          sda_oe_q <= 1'b0;
          if (scl_rise) begin
            if (sda_s2_q)
              st_q <= ST_IGNORE;
            else
              acked_q <= 1'b1;
          end
        end
        ST_IGNORE: begin
          sda_oe_q <= 1'b0;
        end
        default: begin
          sda_oe_q <= 1'b0;
          st_q     <= ST_IDLE;
        end
      endcase
    end
  end

  // prefetch: one request in flight, only while the buffer has room
  always @(posedge sys_clk) begin
    if (reset) begin
      active_q     <= 1'b0;
      pend_q       <= 1'b0;
      rd_req_q     <= 1'b0;
      rd_addr_q    <= {ADDR_W{1'b0}};
      fetch_addr_q <= {ADDR_W{1'b0}};
    end else begin
      rd_req_q <= 1'b0;
      if (rd_valid && buf_in_ready)
        pend_q <= 1'b0;
      if (flush) begin
        active_q <= 1'b0;
      end else if (addr_hit) begin
        active_q     <= 1'b1;
        fetch_addr_q <= target_addr;
      end else if (active_q && !pend_q && !rd_req_q && buf_in_ready) begin
        rd_req_q     <= 1'b1;
        rd_addr_q    <= fetch_addr_q;
        fetch_addr_q <= fetch_addr_q + 1'b1;
        pend_q       <= 1'b1;
      end
    end
  end
endmodule

// ### sim/i2cr_bus_master.sv
// bus master model driving the clock and the data pull-down
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/10ps
module i2cr_bus_master (
  input  wire logic sys_clk,
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // only called from an idle bus, never as a repeated start
  task automatic start();
    sda_low = 1'b0;
    tk(5);
    scl = 1'b1;
    tk(10);
    sda_low = 1'b1;
    tk(10);
    scl = 1'b0;
    tk(5);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    tk(5);
    scl = 1'b1;
    tk(10);
    sda_low = 1'b0;
    tk(10);
  endtask
  // data moves only while the clock is low; sampled mid high phase
  task automatic xfer(input logic b, output logic r);
    sda_low = ~b;
    tk(5);
    scl = 1'b1;
    tk(5);
    r = sda;
    tk(5);
    scl = 1'b0;
    tk(5);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack_n);
    logic x;
    for (int i = 7; i >= 0; i--) xfer(b[i], x);
    xfer(1'b1, ack_n);
  endtask
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic x;
    for (int i = 7; i >= 0; i--) xfer(1'b1, b[i]);
    xfer(last, x);
  endtask
endmodule

// ### sim/i2cr_slave_read_test.sv
// self-checking bench for the read slave
// assumes the master model and checker are compiled first
`timescale 1ns/10ps
module i2cr_slave_read_test;
  logic        sys_clk = 1'b0, reset = 1'b1, strap = 1'b1, busy = 1'b0, alrm = 1'b0;
  logic        rd_valid = 1'b0, rdy, full_seen = 1'b0;
  logic [15:0] tgt = 16'h0000, a;
  logic [7:0]  rd_data = 8'h00;
  wire         scl, m_low, sda_out, sda_oe, boot, sval, alarm_n, alarm_oe, rd_req, rd_ready, act;
  wire  [15:0] rd_addr;
  wire         sda = ~(m_low | sda_oe);
  int          fail_count = 0, checks = 0;
  always #4 sys_clk = ~sys_clk;
  i2cr_bus_master i2cr_bus_master_inst (.sys_clk(sys_clk), .scl(scl), .sda_low(m_low), .sda(sda));
  i2cr_slave_read i2cr_slave_read_inst (.sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .mode_strap_in(strap), .master_boot(boot), .strap_valid(sval),
    .powerup_busy(busy), .alarm_req(alrm), .alarm_out_n(alarm_n), .alarm_oe(alarm_oe),
    .target_addr(tgt), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .read_active(act));
  function automatic logic [7:0] pat(input logic [15:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h5A;
  endfunction
  // register source: fast enough that the buffer fills against a slow master
  // the prefetch only asks while there is room, so a full buffer shows as
  // rd_ready low during a read rather than during a handshake
  always begin
    @(posedge sys_clk);
    #1;
    if (act === 1'b1 && rd_ready === 1'b0) full_seen = 1'b1;
    while (rd_req === 1'b1) begin
      a = rd_addr;
      repeat (2) @(posedge sys_clk);
      #1 rd_valid = 1'b1;
      rd_data = pat(a);
      do begin
        rdy = rd_ready;
        if (rdy !== 1'b1) full_seen = 1'b1;
        @(posedge sys_clk);
      end while (rdy !== 1'b1);
      #1 rd_valid = 1'b0;
    end
  end
  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic t_reset(input logic s);
    strap = s;
    reset = 1'b1;
    tk(12);
    reset = 1'b0;
    tk(8);
    chk(boot, s);
    chk(sval, 1'b1);
  endtask
  task automatic t_read(input logic [15:0] t, input int n);
    logic       ack;
    logic [7:0] b;
    tgt = t; // pointer left by an earlier write
    i2cr_bus_master_inst.start();
    i2cr_bus_master_inst.wbyte(8'h63, ack);
    chk(ack, 1'b0);
    for (int i = 0; i < n; i++) begin
      i2cr_bus_master_inst.rbyte(i == n - 1, b);
      chk(b, pat(t + 16'(i)));
    end
    chk(act, 1'b0);
    // keep clocking with acks but no start: the slave must stay off the line
    i2cr_bus_master_inst.rbyte(1'b0, b);
    chk(b, 8'hFF);
    i2cr_bus_master_inst.stop();
  endtask
  task automatic t_bad();
    logic [7:0] bad [4] = '{8'h62, 8'hE3, 8'h23, 8'h61};
    logic       ack;
    logic [7:0] b;
    foreach (bad[i]) begin
      i2cr_bus_master_inst.start();
      i2cr_bus_master_inst.wbyte(bad[i], ack);
      chk(ack, 1'b1);
      i2cr_bus_master_inst.rbyte(1'b1, b);
      chk(b, 8'hFF);
      i2cr_bus_master_inst.stop();
      chk(act, 1'b0);
    end
  endtask
  task automatic t_busy();
    logic ack;
    busy = 1'b1;
    tk(2);
    chk(alarm_oe, 1'b1);
    i2cr_bus_master_inst.start();
    i2cr_bus_master_inst.wbyte(8'h63, ack);
    chk(ack, 1'b1);
    i2cr_bus_master_inst.stop();
    busy = 1'b0;
    alrm = 1'b1;
    tk(2);
    chk(alarm_oe, 1'b1);
    chk(alarm_n, 1'b0);
    chk(sda_out, 1'b0);
    alrm = 1'b0;
    tk(2);
    chk(alarm_oe, 1'b0);
  endtask
  initial begin
    t_reset(1'b1);
    t_read(16'h00FE, 1);
    t_read(16'h1230, 4);
    t_bad();
    t_busy();
    t_reset(1'b0);
    t_read(16'hABCD, 2);
    chk(full_seen, 1'b1);
    finish_test();
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    finish_test();
  end
endmodule

// ### sim/i2cr_sva.sv
// port checker for the read slave
// assumes binding onto i2cr_slave_read, one clock domain
`timescale 1ns/10ps
module i2cr_sva #(
  parameter ADDR_W = 16
) (
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire logic              sda_out,
  input wire logic              sda_oe,
  input wire logic              master_boot,
  input wire logic              strap_valid,
  input wire logic              powerup_busy,
  input wire logic              alarm_req,
  input wire logic              alarm_out_n,
  input wire logic              alarm_oe,
  input wire logic [ADDR_W-1:0] target_addr,
  input wire logic              rd_req,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic              read_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic              seen_q;
  logic [ADDR_W-1:0] nxt_q;
  always @(posedge sys_clk) begin
    if (reset || !read_active) seen_q <= 1'b0;
    else if (rd_req) seen_q <= 1'b1;
    if (rd_req) nxt_q <= rd_addr + 1'b1;
  end
  property p_od; sda_out == 1'b0 && alarm_out_n == 1'b0; endproperty
  a_od: assert property (p_od) else $error("open-drain pin driven high");
  property p_alarm; (powerup_busy || alarm_req) |=> alarm_oe; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm pin not pulled");
  property p_ack; $rose(read_active) |-> sda_oe; endproperty
  a_ack: assert property (p_ack) else $error("read start without ack");
  property p_first; $rose(read_active) |=> rd_req && rd_addr == target_addr; endproperty
  a_first: assert property (p_first) else $error("first fetch not at target");
  property p_incr; rd_req && seen_q |-> rd_addr == nxt_q; endproperty
  a_incr: assert property (p_incr) else $error("fetch address not ascending");
  property p_pulse; rd_req |-> read_active ##1 !rd_req; endproperty
  a_pulse: assert property (p_pulse) else $error("fetch outside read");
  property p_quiet; sda_oe |-> read_active || $past(read_active); endproperty
  a_quiet: assert property (p_quiet) else $error("data driven while ignoring");
  property p_strap; strap_valid |=> strap_valid && $stable(master_boot); endproperty
  a_strap: assert property (p_strap) else $error("strap capture changed");
  property p_rel; $fell(read_active) |-> !sda_oe; endproperty
  a_rel: assert property (p_rel) else $error("data held at ack clock");
  c_read: cover property ($rose(read_active));
  c_incr: cover property (rd_req && seen_q);
  c_busy: cover property (powerup_busy && alarm_oe);
endmodule
bind i2cr_slave_read i2cr_sva #(.ADDR_W(ADDR_W)) i2cr_sva_inst (.sys_clk(sys_clk), .reset(reset),
  .sda_out(sda_out), .sda_oe(sda_oe), .master_boot(master_boot), .strap_valid(strap_valid),
  .powerup_busy(powerup_busy), .alarm_req(alarm_req), .alarm_out_n(alarm_out_n), .alarm_oe(alarm_oe),
  .target_addr(target_addr), .rd_req(rd_req), .rd_addr(rd_addr), .read_active(read_active));
